// file: logic/ppl_pkg.sv
// Purpose: Shared constants and types for the parallel port latch and direction block.
// Assumes: Classic Wishbone register access, one aligned 32-bit word per register.
// Notes: Printed offsets are not all multiples of four, so each offset is a register index.
// Function
// - Single-chip/boot reset: port C inputs, direction zero.
// - Expanded/test: port C is bus, access external.
// - Writing latched port C drives port C pins.
// - Active strobe edge captures port C pins.
// - Latch read/write clears strobe flag per mode.
// - Pulse control bit 7 sets port A7 direction.
// - Flag clear needs prior control read seeing it.
// - Edge select zero falling, one rising.
package ppl_pkg;
    localparam logic [15:0] IDX_PORT_B_DATA     = 16'h1004;
    localparam logic [15:0] IDX_PORT_C_LATCH    = 16'h1005;
    localparam logic [15:0] IDX_PORT_C_DIR      = 16'h1007;
    localparam logic [15:0] IDX_PORT_D_DATA     = 16'h1008;
    localparam logic [15:0] IDX_PORT_D_DIR      = 16'h1009;
    localparam logic [15:0] IDX_PORT_E_INPUT    = 16'h100A;
    localparam logic [15:0] IDX_PULSE_CTRL      = 16'h1026;
    localparam logic [15:0] IDX_PIO_CONTROL     = 16'h1002;
    localparam logic [15:0] IDX_IRQ_STATUS      = 16'h1040;
    localparam logic [15:0] IDX_IRQ_MASK        = 16'h1041;
    localparam logic [15:0] IDX_EXT_ACCESS      = 16'h1042;
    localparam int          BIT_PIO_FLAG        = 7;
    localparam int          BIT_PIO_STAI        = 6;
    localparam int          BIT_PIO_HNDS        = 4;
    localparam int          BIT_PIO_OIN         = 3;
    localparam int          BIT_PIO_EDGE        = 1;
    localparam int          BIT_PULSE_A7DIR     = 7;
    localparam logic [7:0]  RST_PIO_CONTROL     = 8'h03;
    localparam logic [7:0]  RST_ZERO            = 8'h00;
    localparam logic [7:0]  MASK_PORT_D         = 8'h3F;
    localparam logic [7:0]  MASK_PIO_WRITABLE   = 8'h7F;
    localparam logic [7:0]  MASK_PULSE_WRITABLE = 8'hF3;
    localparam int          IRQ_STROBE          = 0;
    localparam int          IRQ_EXT             = 1;
    localparam logic [1:0]  IRQ_BITS_MASK       = 2'h3;

    typedef enum logic [1:0] {
        PPL_MODE_SINGLE   = 2'b00,
        PPL_MODE_EXPANDED = 2'b01,
        PPL_MODE_BOOT     = 2'b10,
        PPL_MODE_TEST     = 2'b11
    } ppl_mode_t;

    typedef enum logic [1:0] {
        PPL_CLR_IDLE  = 2'b00,
        PPL_CLR_ARMED = 2'b01
    } ppl_clr_t;
endpackage : ppl_pkg

// file: logic/ppl_strobe_if.sv
`timescale 1ns/1ps
// Purpose: Carries the strobe event from the edge detector to the register block.
// Assumes: Single clock domain.
// Notes: The detector drives edgeSeen and the filtered strobe level.
interface ppl_strobe_if;
    logic edgeSeen;
    logic strobeLevel;
    modport detector (output edgeSeen, output strobeLevel);
    modport consumer (input edgeSeen, input strobeLevel);
endinterface : ppl_strobe_if

// file: logic/ppl_strobe_edge.sv
`timescale 1ns/1ps
// Purpose: Synchronises the strobe pin and flags the selected edge.
// Assumes: Strobe pin is asynchronous to clk.
// Notes: A change counts once the second and third stages agree.
module ppl_strobe_edge
    import ppl_pkg::*;
(
    input  wire logic clk,
    input  wire logic rstSyncN,
    input  wire logic strobePin,
    input  wire logic risingSel,
    ppl_strobe_if.detector evt
);
    logic sync1_q;
    logic sync2_q;
    logic sync3_q;
    logic level_q;
    logic edge_q;

    // Three-stage synchroniser; only the second stage reads the first.
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            sync3_q <= 1'b1;
        end else begin
            sync1_q <= strobePin;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // Accepted level changes only when two stages agree, then the chosen edge is flagged.
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            level_q <= 1'b1;
            edge_q  <= 1'b0;
        end else begin
            edge_q <= 1'b0;
            if (sync2_q == sync3_q && sync3_q != level_q) begin
                level_q <= sync3_q;
                edge_q  <= (sync3_q == risingSel);
            end
        end
    end

    assign evt.edgeSeen    = edge_q;
    assign evt.strobeLevel = level_q;
endmodule : ppl_strobe_edge

// file: logic/ppl_port_regs.sv
`timescale 1ns/1ps
// Purpose: Port B/D data, port C/D direction and port E input registers with the strobe-captured port C latch.
// Assumes: Classic Wishbone slave; byte address is four times the register index.
// Notes: Answers every access with ack one cycle after the request; unmapped reads return zero.
module ppl_port_regs
    import ppl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [17:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [1:0]  modePins,
    input  wire logic        strobeAPin,
    input  wire logic [7:0]  portCIn,
    output logic      [7:0]  portCOut,
    output logic      [7:0]  portCOeN,
    output logic      [7:0]  portBOut,
    input  wire logic [5:0]  portDIn,
    output logic      [5:0]  portDOut,
    output logic      [5:0]  portDOeN,
    input  wire logic [7:0]  portEIn,
    output logic             portA7OeN,
    output logic             extAccess,
    output logic             irq
);
    logic       rstMeta_q;
    logic       rstSync_q;
    ppl_mode_t  mode_q;
    logic       modeLatched_q;
    logic [7:0] port_b_data_q;
    logic [7:0] latchC_q;
    logic [7:0] dirC_q;
    logic [5:0] port_d_data_q;
    logic [5:0] dirD_q;
    logic [7:0] pio_q;
    logic [7:0] pulse_q;
    ppl_clr_t   clrState_q;
    logic [1:0] irqStat_q;
    logic [1:0] irqMask_q;
    logic [7:0] cSync1_q;
    logic [7:0] cSync2_q;
    logic [7:0] cSync3_q;
    logic [7:0] cLevel_q;
    logic [7:0] eSync1_q;
    logic [7:0] eSync2_q;
    logic [7:0] eSync3_q;
    logic [7:0] eLevel_q;
    logic [5:0] dSync1_q;
    logic [5:0] dSync2_q;
    logic [5:0] dSync3_q;
    logic [5:0] dLevel_q;
    logic       extAcc_q;
    logic       ack_q;
    logic [31:0] rdat_q;
    logic [7:0] portCOut_q;
    logic [7:0] portCOeN_q;
    logic [5:0] portDOut_q;
    logic [5:0] portDOeN_q;
    logic       irq_q;
    logic       portA7OeN_q;
    logic       busMode;
    logic       req;
    logic       wrStb;
    logic       rdStb;
    logic [15:0] idx;
    logic [7:0] wByte;
    logic       hitLatch;
    logic       flagClear;
    logic       strobeEvt;
    logic [1:0] irqEvt;

    ppl_strobe_if strobeBus ();

    // Edge detector for the strobe A input.
    ppl_strobe_edge u_edge (
        .clk       (clk),
        .rstSyncN  (rstSync_q),
        .strobePin (strobeAPin),
        .risingSel (pio_q[BIT_PIO_EDGE]),
        .evt       (strobeBus.detector)
    );

    // Reset is released through two flip-flops.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end

    // Operating mode pins are caught once, at the first clock after reset release.
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            mode_q        <= PPL_MODE_SINGLE;
            modeLatched_q <= 1'b0;
        end else if (!modeLatched_q) begin
            mode_q        <= ppl_mode_t'(modePins);
            modeLatched_q <= 1'b1;
        end
    end

    // Request decode; a new request is taken only while no ack is out.
    assign busMode   = (mode_q == PPL_MODE_EXPANDED) || (mode_q == PPL_MODE_TEST);
    assign req       = wb_cyc_i && wb_stb_i && !ack_q;
    assign wrStb     = req && wb_we_i && wb_sel_i[0];
    assign rdStb     = req && !wb_we_i;
    assign idx       = wb_adr_i[17:2];
    assign wByte     = wb_dat_i[7:0];
    assign hitLatch  = (idx == IDX_PORT_C_LATCH) && !busMode;
    assign strobeEvt = strobeBus.edgeSeen;
    // Latch access that completes the flag clearing sequence, matched to the handshake mode.
    assign flagClear = hitLatch && (clrState_q == PPL_CLR_ARMED) &&
                       ((pio_q[BIT_PIO_HNDS] && pio_q[BIT_PIO_OIN]) ? wrStb : rdStb);

    // Port C pin synchroniser; a change counts once stages two and three agree.
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            cSync1_q <= RST_ZERO;
            cSync2_q <= RST_ZERO;
            cSync3_q <= RST_ZERO;
            cLevel_q <= RST_ZERO;
        end else begin
            cSync1_q <= portCIn;
            cSync2_q <= cSync1_q;
            cSync3_q <= cSync2_q;
            cLevel_q <= (cSync2_q & cSync3_q) | (cLevel_q & (cSync2_q | cSync3_q));
        end
    end

    // Port E pin synchroniser with the same agreement rule.
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            eSync1_q <= RST_ZERO;
            eSync2_q <= RST_ZERO;
            eSync3_q <= RST_ZERO;
            eLevel_q <= RST_ZERO;
        end else begin
            eSync1_q <= portEIn;
            eSync2_q <= eSync1_q;
            eSync3_q <= eSync2_q;
            eLevel_q <= (eSync2_q & eSync3_q) | (eLevel_q & (eSync2_q | eSync3_q));
        end
    end

    // Port D pin synchroniser with the same agreement rule.
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            dSync1_q <= 6'h00;
            dSync2_q <= 6'h00;
            dSync3_q <= 6'h00;
            dLevel_q <= 6'h00;
        end else begin
            dSync1_q <= portDIn;
            dSync2_q <= dSync1_q;
            dSync3_q <= dSync2_q;
            dLevel_q <= (dSync2_q & dSync3_q) | (dLevel_q & (dSync2_q | dSync3_q));
        end
    end

    // Software-written port and direction registers.
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            port_b_data_q <= RST_ZERO;
            dirC_q  <= RST_ZERO;
            port_d_data_q <= 6'h00;
            dirD_q  <= 6'h00;
            pio_q   <= RST_PIO_CONTROL;
            pulse_q <= RST_ZERO;
        end else begin
            if (wrStb) begin
                case (idx)
                    IDX_PORT_B_DATA: begin
                        port_b_data_q <= wByte;
                    end
                    IDX_PORT_C_DIR: begin
                        if (!busMode) begin
                            dirC_q <= wByte;
                        end
                    end
                    IDX_PORT_D_DATA: begin
                        port_d_data_q <= wByte[5:0];
                    end
                    IDX_PORT_D_DIR: begin
                        dirD_q <= wByte[5:0];
                    end
                    IDX_PULSE_CTRL: begin
                        pulse_q <= wByte & MASK_PULSE_WRITABLE;
                    end
                    IDX_PIO_CONTROL: begin
                        pio_q[6:0] <= wByte[6:0] & MASK_PIO_WRITABLE[6:0];
                    end
                    default: begin
                    end
                endcase
            end
            // The strobe flag: set wins over the clearing latch access.
            if (strobeEvt && !busMode) begin
                pio_q[BIT_PIO_FLAG] <= 1'b1;
            end else if (flagClear) begin
                pio_q[BIT_PIO_FLAG] <= 1'b0;
            end
        end
    end

    // Port C latch: software write or strobe capture; capture wins on a collision.
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            latchC_q <= RST_ZERO;
        end else if (strobeEvt && !busMode) begin
            latchC_q <= cLevel_q;
        end else if (wrStb && hitLatch) begin
            latchC_q <= wByte;
        end
    end

    // Clearing sequence: armed by a control read that sees the flag set.
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            clrState_q <= PPL_CLR_IDLE;
        end else begin
            case (clrState_q)
                PPL_CLR_IDLE: begin
                    if (rdStb && idx == IDX_PIO_CONTROL && pio_q[BIT_PIO_FLAG]) begin
                        clrState_q <= PPL_CLR_ARMED;
                    end
                end
                PPL_CLR_ARMED: begin
                    if (flagClear || !pio_q[BIT_PIO_FLAG]) begin
                        clrState_q <= PPL_CLR_IDLE;
                    end
                end
                default: begin
                    clrState_q <= PPL_CLR_IDLE;
                end
            endcase
        end
    end

    // Interrupt mask register, same layout as the status register.
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            irqMask_q <= 2'h0;
        end else if (wrStb && idx == IDX_IRQ_MASK) begin
            irqMask_q <= wByte[1:0] & IRQ_BITS_MASK;
        end
    end

    // Event sources of the sticky status bits.
    assign irqEvt[IRQ_STROBE] = strobeEvt && !busMode;
    assign irqEvt[IRQ_EXT]    = req && busMode && (idx == IDX_PORT_C_LATCH || idx == IDX_PORT_C_DIR);

    // Sticky interrupt status, write one to clear; a new event wins over the clear.
    for (genvar g = 0; g < 2; g++) begin : gStat
        always_ff @(posedge clk or negedge rstSync_q) begin
            if (!rstSync_q) begin
                irqStat_q[g] <= 1'b0;
            end else if (irqEvt[g]) begin
                irqStat_q[g] <= 1'b1;
            end else if (wrStb && idx == IDX_IRQ_STATUS && wByte[g]) begin
                irqStat_q[g] <= 1'b0;
            end
        end
    end

    // Bus answer: one-cycle ack, registered read data, external access pulse.
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            ack_q    <= 1'b0;
            rdat_q   <= 32'h0000_0000;
            extAcc_q <= 1'b0;
        end else begin
            ack_q    <= req;
            extAcc_q <= irqEvt[IRQ_EXT];
            rdat_q   <= 32'h0000_0000;
            if (rdStb) begin
                case (idx)
                    IDX_PORT_B_DATA:  rdat_q[7:0] <= port_b_data_q;
                    IDX_PORT_C_LATCH: rdat_q[7:0] <= busMode ? RST_ZERO : latchC_q;
                    IDX_PORT_C_DIR:   rdat_q[7:0] <= busMode ? RST_ZERO : dirC_q;
                    IDX_PORT_D_DATA:  rdat_q[5:0] <= (port_d_data_q & dirD_q) | (dLevel_q & ~dirD_q);
                    IDX_PORT_D_DIR:   rdat_q[5:0] <= dirD_q;
                    IDX_PORT_E_INPUT: rdat_q[7:0] <= eLevel_q;
                    IDX_PULSE_CTRL:   rdat_q[7:0] <= pulse_q;
                    IDX_PIO_CONTROL:  rdat_q[7:0] <= pio_q;
                    IDX_IRQ_STATUS:   rdat_q[1:0] <= irqStat_q;
                    IDX_IRQ_MASK:     rdat_q[1:0] <= irqMask_q;
                    default:          rdat_q      <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Port C pin drivers: enables are low while driving; bus modes release port C to the bus logic.
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            portCOut_q <= RST_ZERO;
            portCOeN_q <= 8'hFF;
        end else begin
            portCOut_q <= latchC_q;
            portCOeN_q <= busMode ? 8'hFF : ~dirC_q;
        end
    end

    // Port D and port A7 pin drivers; the outputs come straight from these flops.
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            portDOut_q  <= 6'h00;
            portDOeN_q  <= 6'h3F;
            portA7OeN_q <= 1'b1;
        end else begin
            portDOut_q  <= port_d_data_q;
            portDOeN_q  <= ~dirD_q;
            portA7OeN_q <= ~pulse_q[BIT_PULSE_A7DIR];
        end
    end

    // Level interrupt: an unmasked status bit or the enabled strobe flag.
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irqStat_q & irqMask_q) || (pio_q[BIT_PIO_FLAG] && pio_q[BIT_PIO_STAI]);
        end
    end

    assign wb_dat_o  = rdat_q;
    assign wb_ack_o  = ack_q;
    assign portCOut  = portCOut_q;
    assign portCOeN  = portCOeN_q;
    assign portBOut  = port_b_data_q;
    assign portDOut  = portDOut_q;
    assign portDOeN  = portDOeN_q;
    assign portA7OeN = portA7OeN_q;
    assign extAccess = extAcc_q;
    assign irq       = irq_q;
endmodule : ppl_port_regs

// file: verif/ppl_port_regs_assertions.sv
// Purpose: Watches the bus answer and the pin outputs of the port block.
// Assumes: modePins change only while reset is held low.
// Notes: Two-cycle waits cover the registered pin outputs.
`timescale 1ns/1ps
module ppl_port_regs_assertions
    import ppl_pkg::*;
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [17:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [1:0]  modePins,
    input wire logic [7:0]  portCOut,
    input wire logic [7:0]  portCOeN,
    input wire logic [5:0]  portDOeN,
    input wire logic        portA7OeN,
    input wire logic        extAccess
);
    logic        take;
    logic        wr;
    logic [15:0] idx;
    // Decodes the request that the slave takes at this edge.
    assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr   = take & wb_we_i;
    assign idx  = wb_adr_i[17:2];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_ack; take |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack missing after request");
    property p_ackOne; wb_ack_o |=> !wb_ack_o; endproperty
    a_ackOne: assert property (p_ackOne) else $error("ack longer than one cycle");
    property p_rstC; $rose(rstn) |-> portCOeN == 8'hFF; endproperty
    a_rstC: assert property (p_rstC) else $error("port C driven out of reset");
    property p_wrC; wr && idx == IDX_PORT_C_LATCH && !modePins[0] |-> ##2 portCOut == $past(wb_dat_i[7:0], 2); endproperty
    a_wrC: assert property (p_wrC) else $error("latch write not on pins");
    property p_dirC; wr && idx == IDX_PORT_C_DIR && !modePins[0] |-> ##2 portCOeN == ~$past(wb_dat_i[7:0], 2); endproperty
    a_dirC: assert property (p_dirC) else $error("port C direction wrong");
    property p_dirD; wr && idx == IDX_PORT_D_DIR |-> ##2 portDOeN == ~$past(wb_dat_i[5:0], 2); endproperty
    a_dirD: assert property (p_dirD) else $error("port D direction wrong");
    property p_a7; wr && idx == IDX_PULSE_CTRL |-> ##2 portA7OeN == !$past(wb_dat_i[7], 2); endproperty
    a_a7: assert property (p_a7) else $error("port A7 direction wrong");
    property p_ext; take && modePins[0] && idx == IDX_PORT_C_LATCH |-> ##[1:2] extAccess; endproperty
    a_ext: assert property (p_ext) else $error("bus mode access not external");
    property p_extRd; take && !wb_we_i && modePins[0] && idx == IDX_PORT_C_LATCH |=> wb_dat_o == 32'h0; endproperty
    a_extRd: assert property (p_extRd) else $error("bus mode latch read not zero");
endmodule : ppl_port_regs_assertions

bind ppl_port_regs ppl_port_regs_assertions ppl_port_regs_assertions_i (.clk(clk), .rstn(rstn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .modePins(modePins), .portCOut(portCOut),
    .portCOeN(portCOeN), .portDOeN(portDOeN), .portA7OeN(portA7OeN), .extAccess(extAccess));

// file: verif/ppl_ext_sys.sv
// Purpose: External system that drives strobe A and the port pins.
// Assumes: It drives a port bit only where the block does not.
// Notes: Strobe changes hold for eight cycles to pass the synchroniser.
`timescale 1ns/1ps
module ppl_ext_sys (
    input  wire logic       clk,
    input  wire logic [7:0] portCOut,
    input  wire logic [7:0] portCOeN,
    input  wire logic [5:0] portDOut,
    input  wire logic [5:0] portDOeN,
    output logic      [7:0] portCIn,
    output logic      [5:0] portDIn,
    output logic      [7:0] portEIn,
    output logic            strobeAPin
);
    logic [7:0] extC_q;
    logic [5:0] extD_q;
    // Each pin shows the block's level where it drives, else ours.
    assign portCIn = (portCOeN & extC_q) | (~portCOeN & portCOut);
    assign portDIn = (portDOeN & extD_q) | (~portDOeN & portDOut);
    initial begin
        extC_q = 8'h00;
        extD_q = 6'h00;
        portEIn = 8'h00;
        strobeAPin = 1'b0;
    end
    // Presents new levels on the pins that we drive.
    task automatic setPins(input logic [7:0] c, input logic [5:0] d, input logic [7:0] e);
        @(posedge clk);
        extC_q <= c;
        extD_q <= d;
        portEIn <= e;
    endtask : setPins
    // Moves strobe A to a new level and lets it settle.
    task automatic strobeTo(input logic lvl);
        @(posedge clk);
        strobeAPin <= lvl;
        repeat (8) @(posedge clk);
    endtask : strobeTo
endmodule : ppl_ext_sys

// file: verif/ppl_port_regs_tb_top.sv
// Purpose: Self-checking bench for the port latch and direction block.
// Assumes: A 200 MHz clock; the external model drives the port C, D, E and strobe pins, the bench drives the mode pins.
// Notes: The interrupt mask is taken as one to enable.
`timescale 1ns/1ps
module ppl_port_regs_tb_top
    import ppl_pkg::*;
;
    logic        clk, rstn, cyc, stb, we, ack, strobe, a7OeN, extAcc, irq;
    logic [17:0] adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    logic [1:0]  mode;
    logic [7:0]  cIn, cOut, cOeN, bOut, eIn;
    logic [5:0]  dIn, dOut, dOeN;
    int          failures, compares;
    ppl_port_regs ppl_port_regs_i (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .modePins(mode),
        .strobeAPin(strobe), .portCIn(cIn), .portCOut(cOut), .portCOeN(cOeN), .portBOut(bOut), .portDIn(dIn),
        .portDOut(dOut), .portDOeN(dOeN), .portEIn(eIn), .portA7OeN(a7OeN), .extAccess(extAcc), .irq(irq));
    ppl_ext_sys ppl_ext_sys_i (.clk(clk), .portCOut(cOut), .portCOeN(cOeN), .portDOut(dOut), .portDOeN(dOeN),
        .portCIn(cIn), .portDIn(dIn), .portEIn(eIn), .strobeAPin(strobe));
    // Free-running clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        compares++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    // One classic cycle; holds the request until ack is sampled.
    task automatic wbCycle(input logic [15:0] i, input logic w, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        wdat <= {24'h000000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) chk(8'h00, 8'hFF, "no ack");
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wbCycle
    task automatic wr(input logic [15:0] i, input logic [7:0] d);
        logic [7:0] q;
        wbCycle(i, 1'b1, d, q);
    endtask : wr
    task automatic rdChk(input logic [15:0] i, input logic [7:0] e, input string m);
        logic [7:0] q;
        wbCycle(i, 1'b0, 8'h00, q);
        chk(q, e, m);
    endtask : rdChk
    task automatic doRst(input logic [1:0] m);
        @(posedge clk);
        rstn <= 1'b0;
        mode <= m;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
    endtask : doRst
    task automatic tReset();
        chk(cOeN, 8'hFF, "C dir pins");
        chk({2'b00, dOeN}, 8'h3F, "D dir pins");
        chk({7'h00, a7OeN}, 8'h01, "A7 dir pin");
        rdChk(IDX_PORT_C_DIR, 8'h00, "C dir");
        rdChk(IDX_PORT_B_DATA, 8'h00, "B data");
        rdChk(IDX_PORT_D_DIR, 8'h00, "D dir");
        rdChk(IDX_PULSE_CTRL, 8'h00, "pulse ctl");
        rdChk(IDX_PIO_CONTROL, 8'h03, "pio ctl");
        wr(16'h1003, 8'h55);
        rdChk(16'h1003, 8'h00, "unmapped");
        $display("test reset done");
    endtask : tReset
    task automatic tPorts();
        ppl_ext_sys_i.setPins(8'h3C, 6'h05, 8'hE7);
        wr(IDX_PORT_B_DATA, 8'h96);
        wr(IDX_PORT_C_DIR, 8'h0F);
        wr(IDX_PORT_C_LATCH, 8'hA5);
        wr(IDX_PORT_D_DIR, 8'h2A);
        wr(IDX_PORT_D_DATA, 8'h3F);
        wr(IDX_PULSE_CTRL, 8'h80);
        repeat (3) @(posedge clk);
        chk(bOut, 8'h96, "B pins");
        chk(cOeN, 8'hF0, "C dir pins");
        chk(cOut, 8'hA5, "C pins");
        chk({2'b00, dOeN}, 8'h15, "D dir pins");
        chk({2'b00, dOut}, 8'h3F, "D pins");
        chk({7'h00, a7OeN}, 8'h00, "A7 out");
        rdChk(IDX_PORT_D_DATA, 8'h2F, "D mixed");
        rdChk(IDX_PORT_E_INPUT, 8'hE7, "E pins");
        rdChk(IDX_PULSE_CTRL, 8'h80, "pulse ctl");
        wr(IDX_PULSE_CTRL, 8'h00);
        wr(IDX_PORT_C_DIR, 8'h00);
        $display("test ports done");
    endtask : tPorts
    task automatic tStrobe();
        wr(IDX_PIO_CONTROL, 8'h02);
        ppl_ext_sys_i.setPins(8'h5A, 6'h00, 8'h00);
        ppl_ext_sys_i.strobeTo(1'b1);
        rdChk(IDX_PORT_C_LATCH, 8'h5A, "rise capture");
        rdChk(IDX_PIO_CONTROL, 8'h82, "flag kept");
        rdChk(IDX_PORT_C_LATCH, 8'h5A, "latch again");
        rdChk(IDX_PIO_CONTROL, 8'h02, "flag cleared");
        rdChk(IDX_IRQ_STATUS, 8'h01, "status set");
        chk({7'h00, irq}, 8'h00, "irq masked");
        wr(IDX_IRQ_MASK, 8'h01);
        @(posedge clk);
        chk({7'h00, irq}, 8'h01, "irq on");
        wr(IDX_IRQ_STATUS, 8'h01);
        @(posedge clk);
        chk({7'h00, irq}, 8'h00, "irq cleared");
        wr(IDX_PIO_CONTROL, 8'h00);
        ppl_ext_sys_i.setPins(8'hC3, 6'h00, 8'h00);
        ppl_ext_sys_i.strobeTo(1'b0);
        rdChk(IDX_PIO_CONTROL, 8'h80, "fall flag");
        rdChk(IDX_PORT_C_LATCH, 8'hC3, "fall capture");
        wr(IDX_PIO_CONTROL, 8'h18);
        ppl_ext_sys_i.strobeTo(1'b1);
        ppl_ext_sys_i.strobeTo(1'b0);
        rdChk(IDX_PIO_CONTROL, 8'h98, "out flag");
        rdChk(IDX_PORT_C_LATCH, 8'hC3, "out latch");
        rdChk(IDX_PIO_CONTROL, 8'h98, "read no clear");
        wr(IDX_PORT_C_LATCH, 8'h11);
        rdChk(IDX_PIO_CONTROL, 8'h18, "write clear");
        $display("test strobe done");
    endtask : tStrobe
    task automatic tBus();
        doRst(2'b01);
        wr(IDX_IRQ_MASK, 8'h02);
        rdChk(IDX_PORT_C_LATCH, 8'h00, "bus latch");
        rdChk(IDX_IRQ_STATUS, 8'h02, "ext status");
        chk({7'h00, irq}, 8'h01, "ext irq");
        doRst(2'b11);
        wr(IDX_PORT_C_DIR, 8'h0F);
        rdChk(IDX_PORT_C_DIR, 8'h00, "test dir");
        rdChk(IDX_IRQ_STATUS, 8'h02, "test status");
        doRst(2'b10);
        chk(cOeN, 8'hFF, "boot C pins");
        wr(IDX_PORT_C_DIR, 8'h0F);
        rdChk(IDX_PORT_C_DIR, 8'h0F, "boot dir");
        $display("test bus done");
    endtask : tBus
    // Cuts a hung run short.
    initial begin
        #100000;
        failures++;
        summarize();
    end
    // Main sequence.
    initial begin
        failures = 0;
        compares = 0;
        rstn = 1'b0;
        {cyc, stb, we} = 3'b000;
        adr = 18'h00000;
        sel = 4'hF;
        wdat = 32'h00000000;
        mode = 2'b00;
        doRst(2'b00);
        tReset();
        tPorts();
        tStrobe();
        tBus();
        summarize();
    end
endmodule : ppl_port_regs_tb_top
